/* File: pkg/pie_regs.vh */
// How it works
// [RQ1] Group enable gates every peripheral request
// [RQ2] Enable1 bits 7,6: timer1 gate, ADC
// [RQ3] Enable1 bits 5,4: serial receive, transmit
// [RQ4] Enable1 bits 3,2: sync port1, capcomp1
// [RQ5] Enable1 bits 1,0: timer2 match, timer1 overflow
// [RQ6] Enable2 bit 7: oscillator fail
// [RQ7] Enable2 bits 6,5: comparator2, comparator1
// [RQ8] Enable2 bits 4,3,0: eeprom, collision, capcomp2
// [RQ9] Enable3 bits 5,4: capcomp4, capcomp3
// [RQ10] Enable3 bits 3,1: timer6, timer4 match
// [RQ11] Unimplemented bits read zero, ignore writes
// [RQ12] Enable bits read/write, reset to zero
// [RQ13] Fourth enable register only on large variant
// [RQ14] Flags set regardless of any enable
// [RQ15] Global enable off blocks requests, pending kept
// [RQ16] Software clears flag before enabling source
// [RQ17] Request is OR of flag&enable, gated
`ifndef PIE_REGS_VH
`define PIE_REGS_VH

// Register byte offsets
`define PIE_OFF_CTRL   12'h000
`define PIE_OFF_EN1    12'h004
`define PIE_OFF_EN2    12'h008
`define PIE_OFF_EN3    12'h00c
`define PIE_OFF_EN4    12'h010
`define PIE_OFF_FLAG1  12'h014
`define PIE_OFF_FLAG2  12'h018
`define PIE_OFF_FLAG3  12'h01c
`define PIE_OFF_FLAG4  12'h020
`define PIE_OFF_ISTAT  12'h024
`define PIE_OFF_IMASK  12'h028

// Writable masks of implemented bits
`define PIE_EN1_MASK   8'hff
`define PIE_EN2_MASK   8'hf9
`define PIE_EN3_MASK   8'h3a
`define PIE_EN4_MASK   8'h03

// Control register fields
`define PIE_CTRL_GIE   1
`define PIE_CTRL_PERIPH_GROUP_ENABLE  0

// Reset value of every enable
`define PIE_EN_RST     8'h00

`endif

/* File: rtl/pie_irq_enable.v */
`timescale 1ns/1ns
`include "pie_regs.vh"

module pie_irq_enable #(
	parameter LARGE_VARIANT = 1
) (
	input  wire        mclk_i,
	input  wire        sys_rst_i,
	input  wire        psel_i,
	input  wire        penable_i,
	input  wire        pwrite_i,
	input  wire [11:0] paddr_i,
	input  wire [31:0] pwdata_i,
	output reg  [31:0] prdata_o,
	output reg         pready_o,
	output reg         pslverr_o,
	input  wire [31:0] src_event_i,
	output reg         periph_req_o,
	output reg         irq_o
);

	////////////////////////////////////////////////////////////////////////
	// Storage
	reg        global_irq_enable_q;
	reg        periph_group_enable_q;
	reg [7:0]  periph_irq_enable_1_q;
	reg [7:0]  periph_irq_enable_2_q;
	reg [7:0]  periph_irq_enable_3_q;
	reg [7:0]  periph_irq_enable_4_q;
	reg [31:0] flag_q;
	reg [31:0] flag_d;
	reg [1:0]  istat_q;
	reg [1:0]  istat_d;
	reg [1:0]  imask_q;
	reg        req_d;
	reg [31:0] rdata_d;
	reg        hit_d;

	wire [31:0] en_all;
	wire [31:0] impl_mask;
	wire        wr_en;
	wire        wr_commit;
	wire [7:0]  en4_mask;

	// Per-source view: pending flag that its own enable lets through
	wire [31:0] src_live;
	// One summary bit per enable register, kept apart for timing
	wire [3:0]  grp_pending;
	// Write-one-clear pattern for the flag bank
	wire [31:0] flag_clr;
	// Status event sources
	wire        req_rose;
	wire        flag_new;

	////////////////////////////////////////////////////////////////////////
	// Write strobes, one per register
	wire        wr_ctrl;
	wire        wr_en1;
	wire        wr_en2;
	wire        wr_en3;
	wire        wr_en4;
	wire        wr_flag1;
	wire        wr_flag2;
	wire        wr_flag3;
	wire        wr_flag4;
	wire        wr_istat;
	wire        wr_imask;

	////////////////////////////////////////////////////////////////////////
	// Named enable bits

	// First enable register
	wire        timer1_gate_irq_en;
	wire        adc_irq_en;
	wire        serial_rx_irq_en;
	wire        serial_tx_irq_en;
	wire        sync_port1_irq_en;
	wire        capcomp1_irq_en;
	wire        timer2_match_irq_en;
	wire        timer1_overflow_irq_en;

	// Second enable register
	wire        osc_fail_irq_en;
	wire        comparator2_irq_en;
	wire        comparator1_irq_en;
	wire        eeprom_write_done_irq_en;
	wire        port1_bus_collision_irq_en;
	wire        capcomp2_irq_en;

	// Third enable register
	wire        capcomp4_irq_en;
	wire        capcomp3_irq_en;
	wire        timer6_match_irq_en;
	wire        timer4_match_irq_en;

	// Fourth enable register, large variant only
	wire        port2_bus_collision_irq_en;
	wire        sync_port2_irq_en;

	// Large variant alone carries the fourth register [RQ13]
	assign en4_mask  = (LARGE_VARIANT != 0) ? `PIE_EN4_MASK : 8'h00;
	assign impl_mask = {en4_mask, `PIE_EN3_MASK, `PIE_EN2_MASK, `PIE_EN1_MASK};
	// Ready is registered, so the first access cycle already carries it
	assign wr_en     = psel_i & penable_i & pwrite_i;
	assign wr_commit = wr_en & pready_o;

	// Decode once; every write below keys off one of these
	assign wr_ctrl   = wr_commit & (paddr_i == `PIE_OFF_CTRL);
	assign wr_en1    = wr_commit & (paddr_i == `PIE_OFF_EN1);
	assign wr_en2    = wr_commit & (paddr_i == `PIE_OFF_EN2);
	assign wr_en3    = wr_commit & (paddr_i == `PIE_OFF_EN3);
	assign wr_en4    = wr_commit & (paddr_i == `PIE_OFF_EN4);

	// Flag and status strobes
	assign wr_flag1  = wr_commit & (paddr_i == `PIE_OFF_FLAG1);
	assign wr_flag2  = wr_commit & (paddr_i == `PIE_OFF_FLAG2);
	assign wr_flag3  = wr_commit & (paddr_i == `PIE_OFF_FLAG3);
	assign wr_flag4  = wr_commit & (paddr_i == `PIE_OFF_FLAG4);
	assign wr_istat  = wr_commit & (paddr_i == `PIE_OFF_ISTAT);
	assign wr_imask  = wr_commit & (paddr_i == `PIE_OFF_IMASK);

	////////////////////////////////////////////////////////////////////////
	// Enable bits by source

	// First register: timer, converter, serial and capture sources
	assign timer1_gate_irq_en         = periph_irq_enable_1_q[7]; // [RQ2]
	assign adc_irq_en                 = periph_irq_enable_1_q[6]; // [RQ2]
	assign serial_rx_irq_en           = periph_irq_enable_1_q[5]; // [RQ3]
	assign serial_tx_irq_en           = periph_irq_enable_1_q[4]; // [RQ3]
	assign sync_port1_irq_en          = periph_irq_enable_1_q[3]; // [RQ4]
	assign capcomp1_irq_en            = periph_irq_enable_1_q[2]; // [RQ4]
	assign timer2_match_irq_en        = periph_irq_enable_1_q[1]; // [RQ5]
	assign timer1_overflow_irq_en     = periph_irq_enable_1_q[0]; // [RQ5]

	// Second register: bits 2 and 1 have no source
	assign osc_fail_irq_en            = periph_irq_enable_2_q[7]; // [RQ6]
	assign comparator2_irq_en         = periph_irq_enable_2_q[6]; // [RQ7]
	assign comparator1_irq_en         = periph_irq_enable_2_q[5]; // [RQ7]
	assign eeprom_write_done_irq_en   = periph_irq_enable_2_q[4]; // [RQ8]
	assign port1_bus_collision_irq_en = periph_irq_enable_2_q[3]; // [RQ8]
	assign capcomp2_irq_en            = periph_irq_enable_2_q[0]; // [RQ8]

	// Third register: bits 7, 6, 2 and 0 have no source
	assign capcomp4_irq_en            = periph_irq_enable_3_q[5]; // [RQ9]
	assign capcomp3_irq_en            = periph_irq_enable_3_q[4]; // [RQ9]
	assign timer6_match_irq_en        = periph_irq_enable_3_q[3]; // [RQ10]
	assign timer4_match_irq_en        = periph_irq_enable_3_q[1]; // [RQ10]

	// Fourth register: held at zero on the small variant
	assign port2_bus_collision_irq_en = periph_irq_enable_4_q[1]; // [RQ13]
	assign sync_port2_irq_en          = periph_irq_enable_4_q[0]; // [RQ13]

	// Rebuilt from named bits so a gap can never unmask anything [RQ11]
	assign en_all = {
		6'h00, port2_bus_collision_irq_en, sync_port2_irq_en,
		2'h0, capcomp4_irq_en, capcomp3_irq_en,
		timer6_match_irq_en, 1'b0, timer4_match_irq_en, 1'b0,
		osc_fail_irq_en, comparator2_irq_en, comparator1_irq_en,
		eeprom_write_done_irq_en, port1_bus_collision_irq_en, 2'h0, capcomp2_irq_en,
		timer1_gate_irq_en, adc_irq_en, serial_rx_irq_en, serial_tx_irq_en,
		sync_port1_irq_en, capcomp1_irq_en, timer2_match_irq_en, timer1_overflow_irq_en
	};

	////////////////////////////////////////////////////////////////////////
	// Per-source gating: flag and own enable [RQ17]
	genvar g;
	generate
		for (g = 0; g < 32; g = g + 1) begin : g_live
			assign src_live[g] = flag_q[g] & en_all[g];
		end
	endgenerate

	// Reduce per register first, then across the four
	assign grp_pending[0] = |src_live[7:0];
	assign grp_pending[1] = |src_live[15:8];
	assign grp_pending[2] = |src_live[23:16];
	assign grp_pending[3] = |src_live[31:24];

	// Clear pattern only exists during a committed flag write
	assign flag_clr = {
		wr_flag4 ? pwdata_i[7:0] : 8'h00,
		wr_flag3 ? pwdata_i[7:0] : 8'h00,
		wr_flag2 ? pwdata_i[7:0] : 8'h00,
		wr_flag1 ? pwdata_i[7:0] : 8'h00
	};

	////////////////////////////////////////////////////////////////////////
	// Address decode and read mux
	always @* begin
		hit_d   = 1'b1;
		rdata_d = 32'h0000_0000;
		case (paddr_i)
			`PIE_OFF_CTRL:  rdata_d = {30'h0, global_irq_enable_q, periph_group_enable_q};
			`PIE_OFF_EN1:   rdata_d = {24'h0, periph_irq_enable_1_q};
			`PIE_OFF_EN2:   rdata_d = {24'h0, periph_irq_enable_2_q}; // [RQ11]
			`PIE_OFF_EN3:   rdata_d = {24'h0, periph_irq_enable_3_q}; // [RQ11]
			`PIE_OFF_EN4:   rdata_d = {24'h0, periph_irq_enable_4_q};
			`PIE_OFF_FLAG1: rdata_d = {24'h0, flag_q[7:0]};
			`PIE_OFF_FLAG2: rdata_d = {24'h0, flag_q[15:8]};
			`PIE_OFF_FLAG3: rdata_d = {24'h0, flag_q[23:16]};
			`PIE_OFF_FLAG4: rdata_d = {24'h0, flag_q[31:24]};
			`PIE_OFF_ISTAT: rdata_d = {30'h0, istat_q};
			`PIE_OFF_IMASK: rdata_d = {30'h0, imask_q};
			default:        hit_d   = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Flags: event wins over a write-one clear in the same cycle
	always @* begin
		// Clear first, so a same-cycle event is ORed back in afterwards
		flag_d = flag_q & ~flag_clr;
		// Set independent of enables, global or group [RQ14]
		flag_d = (flag_d | src_event_i) & impl_mask;
	end

	////////////////////////////////////////////////////////////////////////
	// Request: pending flags held while gated off, so they fire later
	always @* begin
		req_d = |grp_pending & periph_group_enable_q // [RQ17] [RQ1]
			& global_irq_enable_q; // [RQ15]
	end

	// Edge of the request and arrival of a fresh flag feed the status bits
	assign req_rose = req_d & ~periph_req_o;
	assign flag_new = |(src_event_i & impl_mask & ~flag_q);

	// Status events: bit0 request rose, bit1 any flag newly set
	always @* begin
		istat_d = istat_q;
		if (wr_istat)
			istat_d = istat_q & ~pwdata_i[1:0];
		// Set after the clear, so an event in the same cycle wins
		if (req_rose)
			istat_d[0] = 1'b1;
		if (flag_new)
			istat_d[1] = 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// Registers
	always @(posedge mclk_i) begin
		if (sys_rst_i) begin
			global_irq_enable_q   <= 1'b0;
			periph_group_enable_q <= 1'b0;
			periph_irq_enable_1_q <= `PIE_EN_RST; // [RQ12]
			periph_irq_enable_2_q <= `PIE_EN_RST;
			periph_irq_enable_3_q <= `PIE_EN_RST;
			periph_irq_enable_4_q <= `PIE_EN_RST;
			flag_q                <= 32'h0000_0000;
			istat_q               <= 2'h0;
			imask_q               <= 2'h0;
			prdata_o              <= 32'h0000_0000;
			pready_o              <= 1'b0;
			pslverr_o             <= 1'b0;
			periph_req_o          <= 1'b0;
			irq_o                 <= 1'b0;
		end else begin
			flag_q       <= flag_d;
			istat_q      <= istat_d;
			periph_req_o <= req_d;
			irq_o        <= |(istat_d & imask_q);
			// Registered ready: set in the first access cycle, so no wait state while outputs stay on flops
			pready_o     <= psel_i & ~penable_i;
			pslverr_o    <= psel_i & ~penable_i & ~hit_d;
			if (psel_i & ~penable_i)
				prdata_o <= hit_d ? rdata_d : 32'h0000_0000;
			// Control: global enable and peripheral group enable
			if (wr_ctrl) begin
				global_irq_enable_q   <= pwdata_i[`PIE_CTRL_GIE];
				periph_group_enable_q <= pwdata_i[`PIE_CTRL_PERIPH_GROUP_ENABLE];
			end
			// Masks drop unimplemented bits [RQ2] [RQ3] [RQ4] [RQ5]
			if (wr_en1)
				periph_irq_enable_1_q <= pwdata_i[7:0] & `PIE_EN1_MASK;
			// [RQ6] [RQ7] [RQ8] [RQ11]
			if (wr_en2)
				periph_irq_enable_2_q <= pwdata_i[7:0] & `PIE_EN2_MASK;
			// [RQ9] [RQ10] [RQ11]
			if (wr_en3)
				periph_irq_enable_3_q <= pwdata_i[7:0] & `PIE_EN3_MASK;
			// Small variant keeps this one at zero [RQ13]
			if (wr_en4)
				periph_irq_enable_4_q <= pwdata_i[7:0] & en4_mask;
			// Interrupt mask for the two status events
			if (wr_imask)
				imask_q <= pwdata_i[1:0];
		end
	end

	// Read data is captured in setup, so it is stable when ready rises;
	// no wait state is needed, every transfer ends in its first access cycle, reads and writes alike

endmodule

/* File: verif/pie_irq_enable_properties.sv */
`timescale 1ns/1ns
// Port-level checks; watches the block's inputs and what it drives
module pie_irq_checker #(parameter LARGE_VARIANT = 1) (
	input wire        mclk_i, sys_rst_i, psel_i, penable_i, pwrite_i,
	input wire [11:0] paddr_i,
	input wire [31:0] pwdata_i, prdata_o, src_event_i,
	input wire        pready_o, pslverr_o, periph_req_o, irq_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);
	wire rd = pready_o && !pwrite_i;
	a_ready_after_setup: assert property (psel_i && !penable_i |=> pready_o)
		else $error("no ready after setup");
	a_ready_one_cycle: assert property (pready_o |=> !pready_o) else $error("ready too long");
	a_error_with_ready: assert property (pslverr_o |-> pready_o) else $error("stray error");
	a_unmapped_error: assert property (pready_o && paddr_i > 12'h028 |-> pslverr_o)
		else $error("unmapped not refused");
	a_en2_gaps: assert property (rd && paddr_i == 12'h008 |-> prdata_o[2:1] == 2'h0)
		else $error("enable2 gap set");
	a_en3_gaps: assert property (rd && paddr_i == 12'h00c |-> !(prdata_o & 32'hffffffc5))
		else $error("enable3 gap set");
	a_upper_zero: assert property (rd && paddr_i inside {12'h004, 12'h008} |-> !prdata_o[31:8])
		else $error("upper bits set");
	// Reset must quiet outputs, so this one is not disabled by reset
	a_reset_clears: assert property (disable iff (1'b0) sys_rst_i |=> !periph_req_o && !irq_o)
		else $error("outputs not cleared");
endmodule
bind pie_irq_enable pie_irq_checker #(.LARGE_VARIANT(LARGE_VARIANT)) pie_irq_checker_i (
	.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i),
	.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
	.src_event_i(src_event_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
	.periph_req_o(periph_req_o), .irq_o(irq_o));

/* File: verif/pie_src_model.sv */
`timescale 1ns/1ns
// Peripheral event sources: registered copy of fire_i, held for as long as fire_i is
module pie_src_model (
	input  wire        mclk_i,
	input  wire [31:0] fire_i,
	output reg  [31:0] src_event_o
);
	initial src_event_o = 32'h0;
	always @(posedge mclk_i) src_event_o <= fire_i;
endmodule

/* File: verif/test_peripheral_interrupt_enables.sv */
`timescale 1ns/1ns
module test_peripheral_interrupt_enables;
	logic        mclk_i = 0, sys_rst_i = 1, psel = 0, pen = 0, pwr = 0, rdy, err, req, irq, e;
	logic [11:0] pa = 12'h000;
	logic [31:0] pwd = 32'h0, fire = 32'h0, prd, ev, r;
	int          errors = 0, tests_run = 0;
	localparam logic [7:0] MSK [4] = '{8'hff, 8'hf9, 8'h3a, 8'h03};
	initial forever #2 mclk_i = ~mclk_i;
	pie_irq_enable pie_irq_enable_i (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .psel_i(psel),
		.penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd),
		.pready_o(rdy), .pslverr_o(err), .src_event_i(ev), .periph_req_o(req), .irq_o(irq));
	pie_src_model pie_src_model_i (.mclk_i(mclk_i), .fire_i(fire), .src_event_o(ev));
	task chk(input string n, input logic [31:0] s, x);
		tests_run++;
		if (s !== x) begin
			errors++;
			$display("FAIL %s exp %h got %h", n, x, s);
		end
	endtask
	// One APB transfer; holds everything until pready is seen at an edge
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		{psel, pen, pwr, pa, pwd} <= {1'b1, 1'b0, w, a, d};
		@(posedge mclk_i);
		pen <= 1'b1;
		do @(posedge mclk_i); while (rdy !== 1'b1);
		{r, e} = {prd, err};
		{psel, pen} <= 2'b00;
	endtask
	// Strobe events, then let flag and request registers settle
	task pulse(input logic [31:0] p);
		@(posedge mclk_i) fire <= p;
		@(posedge mclk_i) fire <= 32'h0;
		repeat (3) @(posedge mclk_i);
		#1;
	endtask
	task t_rw;
		for (int k = 0; k < 4; k++) begin
			apb(0, 12'h004 + 4 * k, 0); chk("rst", r, 0);
			apb(1, 12'h004 + 4 * k, 32'hffffffff); apb(0, 12'h004 + 4 * k, 0);
			chk("rw", r, MSK[k]);
			apb(1, 12'h004 + 4 * k, 0);
		end
		apb(0, 12'h100, 0); chk("slverr", e, 1);
	endtask
	task t_gate;
		apb(1, 12'h004, 32'hff); pulse(32'hffffffff);
		apb(0, 12'h014, 0); chk("flag", r, 32'hff);
		chk("nogroup", req, 0);
		apb(1, 12'h000, 1); pulse(0); chk("noglob", req, 0);
		apb(1, 12'h000, 3); pulse(0); chk("both", req, 1);
		apb(1, 12'h000, 2); pulse(0); chk("grpoff", req, 0);
		apb(1, 12'h004, 0); apb(1, 12'h000, 3);
	endtask
	// Positions 0 to 25 alone: flag cleared first so a stale event cannot fire
	task t_bits;
		for (int i = 0; i < 26; i++) begin
			apb(1, 12'h014 + 4 * (i / 8), 32'hff);
			apb(1, 12'h004 + 4 * (i / 8), 1 << (i % 8)); pulse(1 << i);
			chk("bit", req, MSK[i / 8][i % 8]);
			chk("bitgap", req, MSK[i / 8][i % 8]);
			apb(1, 12'h004 + 4 * (i / 8), 0);
		end
	endtask
	task t_irq;
		apb(1, 12'h028, 1); pulse(0); chk("irq", irq, 1);
		apb(1, 12'h024, 3); pulse(0); chk("irqclr", irq, 0);
	endtask
	task give_verdict;
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge mclk_i);
		sys_rst_i <= 1'b0;
		t_rw; t_gate; t_bits; t_irq;
		give_verdict;
	end
	// Watchdog well beyond the few hundred cycles the tests need
	initial begin
		#60000;
		errors++;
		give_verdict;
	end
endmodule
